// [pkg/urs_pkg.sv]
// shared constants and types for the uart receive status block
package urs_pkg;
    localparam int FIFO_DEPTH = 4;
    localparam logic [2:0] FILL_FULL = 3'h4;
    localparam logic [2:0] FILL_3Q = 3'h3;
    localparam logic [1:0] SEL_FULL = 2'h3;
    localparam logic [1:0] SEL_3Q = 2'h2;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] LAST_BIT_9 = 4'h8;
    // register byte offsets
    localparam logic [7:0] OFF_STS = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_ISTS = 8'h0c;
    localparam logic [7:0] OFF_IMSK = 8'h10;
    // status/control field positions
    localparam int STS_SEL_LSB = 6;
    localparam int STS_ADDR_DETECT_EN = 5;
    localparam int STS_IDLE = 4;
    localparam int STS_PARITY_ERR_FLAG = 3;
    localparam int STS_FRAMING_ERR_FLAG = 2;
    localparam int STS_OVR = 1;
    localparam int STS_AVAIL = 0;
    // config field positions
    localparam int CFG_NINE = 0;
    localparam int CFG_PAR_EN = 1;
    localparam int CFG_PAR_ODD = 2;
    // interrupt status/mask bit positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_ERR = 2;
    // reset values and bus response codes
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [2:0] CFG_RST = 3'h0;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DATA = 4'h2,
        ST_PAR = 4'h4,
        ST_STOP = 4'h8
    } urs_rx_state_e;
endpackage

// [pkg/urs_rx_if.sv]
// link between shift register, receive buffer and status logic
`timescale 1ns/10ps
`default_nettype none
interface urs_rx_if;
    logic done;
    logic [8:0] data;
    logic parity_err_flag;
    logic framing_err_flag;
    logic idle;
    logic abort;
    logic nine;
    logic par_en;
    logic par_odd;
    logic push;
    logic pop;
    logic [8:0] head_data;
    logic head_parity_err_flag;
    logic head_framing_err_flag;
    logic [2:0] fill;
    modport shifter(input abort, nine, par_en, par_odd, output done, data, parity_err_flag, framing_err_flag, idle);
    modport fifo(input push, pop, abort, data, parity_err_flag, framing_err_flag, output head_data, head_parity_err_flag,
        head_framing_err_flag, fill);
endinterface
`default_nettype wire

// [hdl/urs_rx_shift.sv]
// receive shift register and frame sequencer
`timescale 1ns/10ps
`default_nettype none
module urs_rx_shift (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic bit_tick,
    input wire logic rx_s,
    urs_rx_if.shifter rif
);
    import urs_pkg::*;
    urs_rx_state_e state_ff;
    logic [8:0] sh_ff;
    logic [3:0] cnt_ff;
    logic par_ff;
    logic parity_err_flag_ff;
    logic framing_err_flag_ff;
    logic done_ff;

    // config is read live; change it only while idle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            sh_ff <= 9'h000;
            cnt_ff <= 4'h0;
            par_ff <= 1'b0;
            parity_err_flag_ff <= 1'b0;
            framing_err_flag_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (rif.abort) begin
                state_ff <= ST_IDLE;
            end else if (bit_tick) begin
                case (state_ff)
                    ST_IDLE: begin
                        if (!rx_s) begin
                            state_ff <= ST_DATA;
                            cnt_ff <= 4'h0;
                            par_ff <= rif.par_odd;
                        end
                    end
                    ST_DATA: begin
                        sh_ff <= {rx_s, sh_ff[8:1]};
                        par_ff <= par_ff ^ rx_s;
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == (rif.nine ? LAST_BIT_9 : LAST_BIT_8)) begin
                            parity_err_flag_ff <= 1'b0;
                            state_ff <= rif.par_en ? ST_PAR : ST_STOP;
                        end
                    end
                    ST_PAR: begin
                        parity_err_flag_ff <= par_ff ^ rx_s;
                        state_ff <= ST_STOP;
                    end
                    ST_STOP: begin
                        framing_err_flag_ff <= !rx_s;
                        done_ff <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign rif.done = done_ff;
    assign rif.data = rif.nine ? sh_ff : {1'b0, sh_ff[8:1]};
    assign rif.parity_err_flag = parity_err_flag_ff;
    assign rif.framing_err_flag = framing_err_flag_ff;
    assign rif.idle = (state_ff == ST_IDLE);
endmodule // urs_rx_shift
`default_nettype wire

// [hdl/urs_rx_fifo.sv]
// four-character receive buffer with per-character error bits
`timescale 1ns/10ps
`default_nettype none
module urs_rx_fifo (
    input wire logic mclk,
    input wire logic sys_rst,
    urs_rx_if.fifo rif
);
    import urs_pkg::*;
    logic [10:0] mem_ff [FIFO_DEPTH];
    logic [1:0] wp_ff;
    logic [1:0] rp_ff;
    logic [2:0] cnt_ff;
    logic do_push;
    logic do_pop;

    assign do_push = rif.push && (cnt_ff != FILL_FULL);
    assign do_pop = rif.pop && (cnt_ff != 3'h0);

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_ff <= 2'h0;
            rp_ff <= 2'h0;
            cnt_ff <= 3'h0;
        end else if (rif.abort) begin
            wp_ff <= 2'h0;
            rp_ff <= 2'h0;
            cnt_ff <= 3'h0;
        end else begin
            wp_ff <= wp_ff + {1'b0, do_push};
            rp_ff <= rp_ff + {1'b0, do_pop};
            cnt_ff <= cnt_ff + {2'h0, do_push} - {2'h0, do_pop};
        end
    end

    // data storage needs no reset
    always_ff @(posedge mclk) begin
        if (do_push && !rif.abort) begin
            mem_ff[wp_ff] <= {rif.framing_err_flag, rif.parity_err_flag, rif.data};
        end
    end

    assign rif.head_data = mem_ff[rp_ff][8:0];
    assign rif.head_parity_err_flag = mem_ff[rp_ff][9];
    assign rif.head_framing_err_flag = mem_ff[rp_ff][10];
    assign rif.fill = cnt_ff;
endmodule // urs_rx_fifo
`default_nettype wire

// [hdl/urs_rx_status.sv]
// receive status, buffer control and interrupts with an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
module urs_rx_status (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic rx_pin,
    input wire logic bit_tick,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import urs_pkg::*;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    function automatic logic thr_hit(input logic [1:0] sel, input logic [2:0] after);
        if (sel == SEL_FULL) begin
            thr_hit = (after == FILL_FULL);
        end else if (sel == SEL_3Q) begin
            thr_hit = (after == FILL_3Q);
        end else begin
            thr_hit = 1'b1;
        end
    endfunction

    urs_rx_if rif();

    logic rx_meta_ff;
    logic rx_sync_ff;
    logic [1:0] sel_ff;
    logic addr_en_ff;
    logic [2:0] cfg_ff;
    logic ovr_ff;
    logic [2:0] ists_ff;
    logic [2:0] imsk_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic wr_go;
    logic rd_go;
    logic wr_lane0;
    logic wr_sts;
    logic wr_ists;
    logic wr_map;
    logic rd_map;
    logic keep;
    logic full;
    logic ovr_set;
    logic ovr_clr;
    logic [2:0] fill_after;
    logic [2:0] evt;
    logic [31:0] sts_word;
    logic [31:0] rd_word;

    // rx pin is asynchronous, idle high
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
        end else begin
            rx_meta_ff <= rx_pin;
            rx_sync_ff <= rx_meta_ff;
        end
    end

    urs_rx_shift u_shift (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .bit_tick(bit_tick),
        .rx_s(rx_sync_ff),
        .rif(rif)
    );

    urs_rx_fifo u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .rif(rif)
    );

    // bus handshakes: one write and one read in flight
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    assign rd_go = s_axi_arvalid && !rvalid_ff;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !rvalid_ff;
    assign wr_lane0 = wr_go && s_axi_wstrb[0];
    assign wr_sts = wr_lane0 && hit(s_axi_awaddr, OFF_STS);
    assign wr_ists = wr_lane0 && hit(s_axi_awaddr, OFF_ISTS);
    assign wr_map = hit(s_axi_awaddr, OFF_STS) || hit(s_axi_awaddr, OFF_CFG)
        || hit(s_axi_awaddr, OFF_DATA) || hit(s_axi_awaddr, OFF_ISTS)
        || hit(s_axi_awaddr, OFF_IMSK);
    assign rd_map = hit(s_axi_araddr, OFF_STS) || hit(s_axi_araddr, OFF_CFG)
        || hit(s_axi_araddr, OFF_DATA) || hit(s_axi_araddr, OFF_ISTS)
        || hit(s_axi_araddr, OFF_IMSK);

    assign rif.nine = cfg_ff[CFG_NINE];
    assign rif.par_en = cfg_ff[CFG_PAR_EN];
    assign rif.par_odd = cfg_ff[CFG_PAR_ODD];
    assign full = (rif.fill == FILL_FULL);

    // address filter only in nine-bit mode
    assign keep = rif.done && !(addr_en_ff && rif.nine && !rif.data[8]);
    assign rif.push = keep && !ovr_ff && !full;
    // overflow when a kept character meets a full buffer
    assign ovr_set = keep && !ovr_ff && full;
    // one-to-zero write on the overrun bit
    assign ovr_clr = wr_sts && ovr_ff && !s_axi_wdata[STS_OVR];
    assign rif.abort = ovr_clr;
    // popping a data read drains the head; empty reads return stale data
    assign rif.pop = rd_go && hit(s_axi_araddr, OFF_DATA) && (rif.fill != 3'h0);
    assign fill_after = rif.fill + 3'h1 - {2'h0, rif.pop};

    assign evt[IRQ_RX] = rif.push && thr_hit(sel_ff, fill_after);
    assign evt[IRQ_OVR] = ovr_set;
    assign evt[IRQ_ERR] = rif.push && (rif.parity_err_flag || rif.framing_err_flag);

    // control fields writable through byte lane 0
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_ff <= SEL_RST;
            addr_en_ff <= 1'b0;
            cfg_ff <= CFG_RST;
            imsk_ff <= IRQ_RST;
        end else if (wr_lane0) begin
            if (hit(s_axi_awaddr, OFF_STS)) begin
                sel_ff <= s_axi_wdata[STS_SEL_LSB +: 2];
                addr_en_ff <= s_axi_wdata[STS_ADDR_DETECT_EN];
            end else if (hit(s_axi_awaddr, OFF_CFG)) begin
                cfg_ff <= s_axi_wdata[2:0];
            end else if (hit(s_axi_awaddr, OFF_IMSK)) begin
                imsk_ff <= s_axi_wdata[2:0];
            end
        end
    end

    // software may clear but never set
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ovr_ff <= 1'b0;
        end else begin
            ovr_ff <= ovr_set || (ovr_ff && !ovr_clr);
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ists_ff <= IRQ_RST;
        end else begin
            ists_ff <= evt | (ists_ff & ~(wr_ists ? s_axi_wdata[2:0] : 3'h0));
        end
    end

    assign irq = |(ists_ff & imsk_ff);

    assign sts_word = {24'h000000, sel_ff, addr_en_ff, rif.idle,
        (rif.fill != 3'h0) && rif.head_parity_err_flag, (rif.fill != 3'h0) && rif.head_framing_err_flag,
        ovr_ff, rif.fill != 3'h0};

    always_comb begin
        rd_word = 32'h00000000;
        if (hit(s_axi_araddr, OFF_STS)) begin
            rd_word = sts_word;
        end else if (hit(s_axi_araddr, OFF_CFG)) begin
            rd_word = {29'h00000000, cfg_ff};
        end else if (hit(s_axi_araddr, OFF_DATA)) begin
            rd_word = {23'h000000, rif.head_data};
        end else if (hit(s_axi_araddr, OFF_ISTS)) begin
            rd_word = {29'h00000000, ists_ff};
        end else if (hit(s_axi_araddr, OFF_IMSK)) begin
            rd_word = {29'h00000000, imsk_ff};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else if (rd_go) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_map ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    thr_full_a: assert property (
        (rif.push && sel_ff == SEL_FULL && rif.fill == 3'h3 && !rif.pop) |=> ists_ff[IRQ_RX])
        else $error("full threshold event missing");

    thr_full_quiet_a: assert property (
        (rif.push && sel_ff == SEL_FULL && rif.fill == 3'h1 && !rif.pop
        && !ists_ff[IRQ_RX]) |=> !ists_ff[IRQ_RX])
        else $error("full threshold fired early");

    thr_three_a: assert property (
        (rif.push && sel_ff == SEL_3Q && rif.fill == 3'h2 && !rif.pop) |=> ists_ff[IRQ_RX])
        else $error("three quarter event missing");

    thr_any_a: assert property (
        (rif.push && !sel_ff[1]) |=> ists_ff[IRQ_RX])
        else $error("any character event missing");

    addr_drop_a: assert property (
        (rif.done && addr_en_ff && rif.nine && !rif.data[8]) |-> !rif.push && !ovr_set)
        else $error("non-address character accepted");

    addr_pass_a: assert property (
        (rif.done && !rif.nine && !ovr_ff && !full) |-> rif.push)
        else $error("eight-bit character filtered");

    idle_flag_a: assert property (
        $fell(rif.idle) |-> ##1 !s_axi_rdata[STS_IDLE] || !$past(hit(s_axi_araddr, OFF_STS)
        && rd_go))
        else $error("idle flag wrong while receiving");

    idle_done_a: assert property (
        rif.done |-> rif.idle)
        else $error("busy flag at frame end");

    parity_err_flag_head_a: assert property (
        (rif.push && rif.fill == 3'h0) |=> sts_word[STS_PARITY_ERR_FLAG] == $past(rif.parity_err_flag))
        else $error("parity flag wrong for head");

    parity_err_flag_off_a: assert property (
        (rif.done && !rif.par_en) |-> !rif.parity_err_flag)
        else $error("parity error without parity");

    head_hold_a: assert property (
        (!rif.pop && !rif.abort && rif.fill != 3'h0) |=> $stable(rif.head_data)
        && $stable(rif.head_parity_err_flag) && $stable(rif.head_framing_err_flag))
        else $error("head character changed without read");

    framing_err_flag_head_a: assert property (
        (rif.push && rif.framing_err_flag && rif.fill == 3'h0) |=> sts_word[STS_FRAMING_ERR_FLAG])
        else $error("framing flag missing for head");

    ovr_set_a: assert property (
        (keep && full && !ovr_ff) |=> ovr_ff [*2] or (ovr_ff ##1 !ovr_ff))
        else $error("overrun not set on overflow");

    ovr_sw_a: assert property (
        (!ovr_ff && !(keep && full)) |=> !ovr_ff)
        else $error("overrun set without overflow");

    ovr_flush_a: assert property (
        ovr_clr |=> (rif.fill == 3'h0) && rif.idle && !ovr_ff)
        else $error("overrun clear did not flush");

    avail_a: assert property (
        rif.push |=> sts_word[STS_AVAIL])
        else $error("data available not set");

    avail_drop_a: assert property (
        (rif.pop && rif.fill == 3'h1 && !rif.push) |=> !sts_word[STS_AVAIL])
        else $error("data available after last read");

    fill_bound_a: assert property (
        rif.fill <= FILL_FULL)
        else $error("buffer count out of range");

    ovr_hold_a: assert property (
        ovr_ff |-> !rif.push ##1 (rif.fill <= $past(rif.fill)))
        else $error("transfer during overrun");

    // sticky event bits
    ists_sticky_a: assert property (
        (ists_ff[IRQ_RX] && !wr_ists) |=> ists_ff[IRQ_RX])
        else $error("event bit lost without clear");

    ists_w1c_a: assert property (
        (wr_ists && s_axi_wdata[IRQ_OVR] && !ovr_set) |=> !ists_ff[IRQ_OVR])
        else $error("event bit not cleared");

    // bus answers: one cycle late, held until taken
    wr_answer_a: assert property (
        (s_axi_awvalid && s_axi_awready) |=> s_axi_bvalid)
        else $error("write response missing");

    bresp_hold_a: assert property (
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    rd_answer_a: assert property (
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read response missing");

    rdata_hold_a: assert property (
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata)
        && $stable(s_axi_rresp))
        else $error("read response dropped early");

    fill_cov: cover property (rif.push && rif.fill == 3'h3);
    ovr_cov: cover property (ovr_set ##[1:200] ovr_clr);
    irq_cov: cover property ($rose(irq));
    three_cov: cover property (evt[IRQ_RX] && sel_ff == SEL_3Q);
    err_cov: cover property (evt[IRQ_ERR]);
endmodule // urs_rx_status
`default_nettype wire

// [verification/urs_tx_model.sv]
// remote serial transmitter and bit tick source driving the receive pin
`timescale 1ns/10ps
`default_nettype none
module urs_tx_model (
    input wire logic mclk,
    input wire logic sys_rst,
    output logic rx_pin,
    output logic bit_tick
);
    logic [2:0] phase_ff;

    // free baud divider, eight clocks a bit, tick at the bit centre
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_ff <= 3'h0;
        end else begin
            phase_ff <= phase_ff + 3'h1;
        end
    end
    assign bit_tick = (phase_ff == 3'h4);

    initial begin
        rx_pin = 1'b1;
    end

    // line moves only at phase 0 so the receiver samples mid-bit after its sync delay
    task automatic send(input logic [8:0] d, input logic nine, input logic par_en,
        input logic par_odd, input logic bad_par, input logic bad_stop);
        logic [11:0] bits;
        int nb;
        int n;
        bits = 12'h0;
        nb = nine ? 9 : 8;
        for (int i = 0; i < nb; i++) bits[i + 1] = d[i];
        n = nb + 1;
        if (par_en) begin
            bits[n] = ^(nine ? d : {1'b0, d[7:0]}) ^ par_odd ^ bad_par;
            n++;
        end
        bits[n] = ~bad_stop;
        n++;
        do @(posedge mclk); while (phase_ff !== 3'h7);
        for (int i = 0; i < n; i++) begin
            rx_pin <= bits[i];
            repeat (8) @(posedge mclk);
        end
        // released line returns to its idle high level
        rx_pin <= 1'b1;
    endtask
endmodule // urs_tx_model
`default_nettype wire

// [verification/urs_rx_status_tb.sv]
// self-checking bench for the uart receive status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module urs_rx_status_tb;
    import urs_pkg::*;
    logic mclk;
    logic sys_rst;
    logic rx_pin;
    logic bit_tick;
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic irq;
    logic [1:0] resp;
    int bad_count = 0;
    int num_checks = 0;
    logic [7:0] offs [4] = '{OFF_STS, OFF_CFG, OFF_ISTS, OFF_IMSK};
    // error cases: odd parity, bad parity, bad stop
    logic [2:0] ecase [4] = '{3'b010, 3'b100, 3'b110, 3'b001};

    urs_rx_status urs_rx_status_inst (.mclk(mclk), .sys_rst(sys_rst), .rx_pin(rx_pin),
        .bit_tick(bit_tick), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
    urs_tx_model urs_tx_model_inst (.mclk(mclk), .sys_rst(sys_rst), .rx_pin(rx_pin),
        .bit_tick(bit_tick));

    function automatic logic exp_evt(input logic [1:0] sel, input int fill);
        if (sel == SEL_FULL) return fill >= 4;
        if (sel == SEL_3Q) return fill >= 3;
        return fill >= 1;
    endfunction

    // starts one edge in so a lowered valid never meets a raised one in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // longest run is some thirty frames of about a hundred clocks
    initial begin
        repeat (30000) @(posedge mclk);
        bad_count++;
        results();
    end

    initial begin
        logic [31:0] v;
        logic [8:0] ch [1:6];
        logic [2:0] cs;
        sys_rst = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        void'($urandom(32'h4638));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(offs[i], v);
            `CHK({v, resp}, {((i == 0) ? 32'h10 : 32'h0), RESP_OKAY})
        end
        rd(8'h14, v);
        `CHK({v, resp}, {32'h0, RESP_SLVERR})
        wr(8'h14, 32'h0);
        `CHK(resp, RESP_SLVERR)
        // a write without byte lane 0 must change nothing
        s_axi_wstrb <= 4'he;
        wr(OFF_IMSK, 32'h7);
        s_axi_wstrb <= 4'hf;
        rd(OFF_IMSK, v);
        `CHK(v, 32'h0)
        wr(OFF_DATA, 32'h1ff);
        `CHK(resp, RESP_OKAY)
        // read-only flags and overrun must ignore a write of ones
        wr(OFF_STS, 32'hff);
        rd(OFF_STS, v);
        `CHK(v, 32'hf0)
        $display("test reset_access done");
        wr(OFF_IMSK, 32'h1);
        for (int sel = 0; sel < 4; sel++) begin
            wr(OFF_STS, 32'(sel) << STS_SEL_LSB);
            wr(OFF_ISTS, 32'h7);
            for (int k = 1; k <= 4; k++) begin
                ch[k] = 9'($urandom_range(255));
                urs_tx_model_inst.send(ch[k], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
                rd(OFF_ISTS, v);
                `CHK(v[IRQ_RX], exp_evt(2'(sel), k))
                `CHK(irq, exp_evt(2'(sel), k))
            end
            rd(OFF_STS, v);
            `CHK(v[STS_AVAIL], 1'b1)
            for (int k = 1; k <= 4; k++) begin
                rd(OFF_DATA, v);
                `CHK(v[8:0], ch[k])
            end
            rd(OFF_STS, v);
            `CHK(v[STS_AVAIL], 1'b0)
        end
        wr(OFF_IMSK, 32'h0);
        `CHK(irq, 1'b0)
        wr(OFF_STS, 32'h0);
        wr(OFF_ISTS, 32'h7);
        $display("test thresholds done");
        for (int k = 1; k <= 6; k++) ch[k] = 9'($urandom_range(255));
        for (int k = 1; k <= 5; k++) urs_tx_model_inst.send(ch[k], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFF_STS, v);
        `CHK({v[STS_OVR], v[STS_AVAIL]}, 2'b11)
        rd(OFF_ISTS, v);
        `CHK(v[IRQ_OVR], 1'b1)
        rd(OFF_DATA, v);
        `CHK(v[8:0], ch[1])
        // a freed slot must still refuse characters while overrun stands
        urs_tx_model_inst.send(ch[6], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFF_DATA, v);
        `CHK(v[8:0], ch[2])
        wr(OFF_STS, 32'h0);
        rd(OFF_STS, v);
        `CHK({v[STS_OVR], v[STS_AVAIL]}, 2'b00)
        urs_tx_model_inst.send(ch[6], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFF_DATA, v);
        `CHK(v[8:0], ch[6])
        wr(OFF_ISTS, 32'h7);
        $display("test overrun done");
        for (int j = 0; j < 4; j++) begin
            cs = ecase[j];
            wr(OFF_CFG, {29'h0, cs[2], 1'b1, 1'b0});
            urs_tx_model_inst.send(9'($urandom_range(255)), 1'b0, 1'b1, cs[2], cs[1], cs[0]);
            rd(OFF_STS, v);
            `CHK({v[STS_PARITY_ERR_FLAG], v[STS_FRAMING_ERR_FLAG]}, cs[1:0])
            rd(OFF_ISTS, v);
            `CHK(v[IRQ_ERR], |cs[1:0])
            wr(OFF_ISTS, 32'h7);
            rd(OFF_DATA, v);
        end
        $display("test errors done");
        wr(OFF_CFG, 32'h1);
        wr(OFF_STS, 32'h1 << STS_ADDR_DETECT_EN);
        ch[1] = {1'b0, 8'($urandom_range(255))};
        ch[2] = {1'b1, 8'($urandom_range(255))};
        urs_tx_model_inst.send(ch[1], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        urs_tx_model_inst.send(ch[2], 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFF_DATA, v);
        `CHK(v[8:0], ch[2])
        rd(OFF_STS, v);
        `CHK(v[STS_AVAIL], 1'b0)
        // eight-bit mode: enable alone must not filter
        wr(OFF_CFG, 32'h0);
        urs_tx_model_inst.send(ch[1], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFF_DATA, v);
        `CHK(v[8:0], ch[1])
        $display("test address_detect done");
        fork
            urs_tx_model_inst.send(ch[3], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            begin
                repeat (40) @(posedge mclk);
                rd(OFF_STS, v);
                `CHK(v[STS_IDLE], 1'b0)
            end
        join
        rd(OFF_STS, v);
        `CHK(v[STS_IDLE], 1'b1)
        $display("test idle done");
        results();
    end
endmodule // urs_rx_status_tb
`default_nettype wire
